// File: hw/ebtc_consts.svh
`ifndef EBTC_CONSTS_SVH
`define EBTC_CONSTS_SVH
// Option field positions
`define EBTC_OPT_CS_BIT 5
`define EBTC_OPT_SE_BIT 4
`define EBTC_OPT_PSA_BIT 3
// Reset values
`define EBTC_OPTION_RST 8'hFF
`define EBTC_COUNT_RST 8'h00
// Count increments held off after a write
`define EBTC_WR_HOLD 2'h2
// Last quarter phase of an instruction cycle
`define EBTC_QPHASES 2'h3
`endif

// File: hw/ebtc_pkg.sv
package ebtc_pkg;
    // Configuration bits from the option register
    typedef struct packed {
        logic clock_source_select;
        logic source_edge_select;
        logic prescaler_assign;
        logic [2:0] prescale_ratio_field;
    } ebtc_cfg_t;
    // Software write request to the count register
    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } ebtc_wr_t;
endpackage

// File: hw/ebtc_timer.sv
`timescale 1ns/1ps
`include "ebtc_consts.svh"
// Operation
// - Source select zero counts instruction cycles, one per cycle unprescaled.
// - A count write holds off the next two count increments.
// - Source select one counts selected edges on the external input.
// - Edge select zero means rising edges, one means falling edges.
// - Prescaler shared with watchdog; assign bit zero gives it to counter.
// - Software has no access to the prescaler count.
// - Counter prescaler supports ratios 1:2 through 1:256.
// - Count wrap from FFh to 00h sets the overflow flag.
// - Interrupt request only while overflow interrupt enable is set.
// - Overflow flag stays set until software clears it.
// - Counter stops during sleep; overflow cannot wake the processor.
// - Count source sampled on second and fourth quarter phases.
// - Count write clears prescaler when prescaler belongs to counter.
module ebtc_timer
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic NRST_IN,
    // Configuration and control
    input wire ebtc_pkg::ebtc_cfg_t CFG_IN,
    input wire ebtc_pkg::ebtc_wr_t COUNT_WR_IN,
    input wire logic FLAG_CLR_IN,
    input wire logic IRQ_ENABLE_IN,
    input wire logic SLEEP_IN,
    // External pulse source
    input wire logic EXT_COUNT_IN,
    // Watchdog tick to be prescaled
    input wire logic WDT_TICK_IN,
    // Status
    output logic [7:0] COUNT_OUT,
    output logic OVERFLOW_FLAG_OUT,
    output logic IRQ_OUT,
    output logic WDT_PRESCALED_OUT
);
    logic [2:0] ext_sync_q, ext_sync_d;
    logic [1:0] qph_q, qph_d;
    logic samp_q, samp_d;
    logic samp_prev_q, samp_prev_d;
    logic [7:0] pre_q, pre_d;
    logic [7:0] cnt_q, cnt_d;
    logic [1:0] hold_q, hold_d;
    logic flag_q, flag_d;
    logic irq_q, irq_d;
    logic wdt_out_q, wdt_out_d;
    logic ext_clean_q, ext_clean_d;
    logic ext_prev_q, ext_prev_d;
    logic src_tick, pre_tick, cnt_tick, ext_edge, wrap, samp_now, cyc_tick;

    // Ratio mask: terminal count of the prescaler
    function automatic logic [7:0] ebtc_ratio_mask(input logic [2:0] n);
        ebtc_ratio_mask = 8'(({1'b0, 8'hFF} << (4'(n) + 4'h1)) >> 9'h0);
        ebtc_ratio_mask = ~ebtc_ratio_mask;
    endfunction

    // Input synchroniser, clean level, edge detect and quarter phase
    always_comb
    begin
        ext_sync_d = {ext_sync_q[1:0], EXT_COUNT_IN};
        ext_clean_d = (ext_sync_q[1] == ext_sync_q[2]) ? ext_sync_q[2] : ext_clean_q;
        ext_prev_d = ext_clean_q;
        ext_edge = CFG_IN.source_edge_select ? (ext_prev_q & ~ext_clean_q)
                                             : (~ext_prev_q & ext_clean_q);
        qph_d = SLEEP_IN ? qph_q : qph_q + 2'h1;
        cyc_tick = ~SLEEP_IN && (qph_q == `EBTC_QPHASES);
    end

    // Source select, prescaler, Q2/Q4 sampling
    always_comb
    begin
        src_tick = CFG_IN.clock_source_select ? ext_edge : cyc_tick;
        pre_d = pre_q;
        pre_tick = 1'b0;
        wdt_out_d = 1'b0;
        if (CFG_IN.prescaler_assign == 1'b0)
        begin
            if (COUNT_WR_IN.wr)
                pre_d = 8'h00;
            else if (src_tick && !SLEEP_IN)
            begin
                if ((pre_q & ebtc_ratio_mask(CFG_IN.prescale_ratio_field)) ==
                    ebtc_ratio_mask(CFG_IN.prescale_ratio_field))
                begin
                    pre_d = 8'h00;
                    pre_tick = 1'b1;
                end
                else
                    pre_d = pre_q + 8'h01;
            end
        end
        else if (WDT_TICK_IN)
        begin
            if ((pre_q & ebtc_ratio_mask(CFG_IN.prescale_ratio_field)) ==
                ebtc_ratio_mask(CFG_IN.prescale_ratio_field))
            begin
                pre_d = 8'h00;
                wdt_out_d = 1'b1;
            end
            else
                pre_d = pre_q + 8'h01;
        end
        // Sampled level toggles on each prescaled tick; taken on Q2 and Q4
        samp_now = qph_q[0];
        samp_d = samp_q;
        if (pre_tick || (CFG_IN.prescaler_assign && src_tick && !SLEEP_IN))
            samp_d = ~samp_q;
        samp_prev_d = samp_now ? samp_q : samp_prev_q;
        cnt_tick = samp_now && (samp_q != samp_prev_q);
    end

    // Count register, write hold-off, overflow flag
    always_comb
    begin
        cnt_d = cnt_q;
        hold_d = hold_q;
        wrap = 1'b0;
        if (COUNT_WR_IN.wr)
        begin
            cnt_d = COUNT_WR_IN.data;
            hold_d = `EBTC_WR_HOLD;
        end
        else if (cnt_tick && !SLEEP_IN)
        begin
            if (hold_q != 2'h0)
                hold_d = hold_q - 2'h1;
            else
            begin
                cnt_d = cnt_q + 8'h01;
                wrap = (cnt_q == 8'hFF);
            end
        end
        flag_d = wrap ? 1'b1 : (FLAG_CLR_IN ? 1'b0 : flag_q);
        irq_d = flag_d & IRQ_ENABLE_IN;
    end

    // Registers; prescaler count never reaches a port
    always_ff @(posedge MCLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            ext_sync_q <= 3'h0;
            ext_clean_q <= 1'b0;
            ext_prev_q <= 1'b0;
            qph_q <= 2'h0;
            pre_q <= 8'h00;
            samp_q <= 1'b0;
            samp_prev_q <= 1'b0;
            cnt_q <= `EBTC_COUNT_RST;
            hold_q <= 2'h0;
            flag_q <= 1'b0;
            irq_q <= 1'b0;
            wdt_out_q <= 1'b0;
        end
        else
        begin
            ext_sync_q <= ext_sync_d;
            ext_clean_q <= ext_clean_d;
            ext_prev_q <= ext_prev_d;
            qph_q <= qph_d;
            pre_q <= pre_d;
            samp_q <= samp_d;
            samp_prev_q <= samp_prev_d;
            cnt_q <= cnt_d;
            hold_q <= hold_d;
            flag_q <= flag_d;
            irq_q <= irq_d;
            wdt_out_q <= wdt_out_d;
        end
    end

    // Outputs straight from their registers
    assign COUNT_OUT = cnt_q;
    assign OVERFLOW_FLAG_OUT = flag_q;
    assign IRQ_OUT = irq_q;
    assign WDT_PRESCALED_OUT = wdt_out_q;

    // Flag set by a wrap persists until a clear arrives
    chk_flag_sticky: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        flag_q && !FLAG_CLR_IN |=> flag_q) else $error("overflow flag dropped");
    chk_flag_wrap: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        wrap |=> flag_q && cnt_q == 8'h00) else $error("wrap did not set flag");
    chk_irq_mask: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        !IRQ_ENABLE_IN |=> !irq_q) else $error("irq while masked");
    chk_sleep_stop: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        SLEEP_IN && !COUNT_WR_IN.wr |=> $stable(cnt_q)) else $error("count moved in sleep");
    chk_write_load: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        COUNT_WR_IN.wr |=> cnt_q == $past(COUNT_WR_IN.data) && hold_q == 2'h2)
        else $error("write not loaded");
    chk_hold_inc: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        hold_q != 2'h0 && !COUNT_WR_IN.wr |=> cnt_q == $past(cnt_q))
        else $error("count advanced during hold");
    chk_pre_clear: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        COUNT_WR_IN.wr && !CFG_IN.prescaler_assign |=> pre_q == 8'h00)
        else $error("prescaler not cleared");
    chk_step_one: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        !COUNT_WR_IN.wr |=> cnt_q == $past(cnt_q) || cnt_q == 8'($past(cnt_q) + 8'h01))
        else $error("count step not one");

    // Phase, prescaler owner, edge, irq, clear, sleep and hold guards
    chk_tick_phase: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        !COUNT_WR_IN.wr && !qph_q[0] |=> $stable(cnt_q))
        else $error("count moved off a sample phase");
    chk_wdt_owner: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        !CFG_IN.prescaler_assign |=> !wdt_out_q)
        else $error("watchdog pulse without prescaler");
    chk_edge_single: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        ext_edge |=> !ext_edge)
        else $error("one pin edge seen twice");
    chk_irq_follow: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        IRQ_ENABLE_IN && flag_q && !FLAG_CLR_IN |=> irq_q)
        else $error("enabled flag gave no irq");
    chk_flag_clear: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        FLAG_CLR_IN && !wrap |=> !flag_q)
        else $error("flag clear ignored");
    chk_sleep_phase: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        SLEEP_IN |=> $stable(qph_q))
        else $error("phase moved in sleep");
    chk_hold_count: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        hold_q != 2'h0 && cnt_tick && !SLEEP_IN && !COUNT_WR_IN.wr
        |=> hold_q == $past(hold_q) - 2'h1)
        else $error("hold did not count down");
endmodule

// File: test/ebtc_pulse_src.sv
`timescale 1ns/1ps
// External pulse source on the count input pin
module ebtc_pulse_src
(
    // Clock
    input wire logic MCLK_IN,
    // Pin towards the block
    output logic PIN_OUT
);
    // Pin rests low between bursts
    initial PIN_OUT = 1'b0;
    // Send n pulses, high held 8 clocks, low held 9 clocks between pulses
    task automatic send(input int n);
        repeat (n)
        begin
            @(posedge MCLK_IN);
            #1 PIN_OUT = 1'b1;
            repeat (8) @(posedge MCLK_IN);
            #1 PIN_OUT = 1'b0;
            repeat (8) @(posedge MCLK_IN);
        end
    endtask
endmodule

// File: test/ebtc_timer_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
// Bench for the eight bit timer counter
module ebtc_timer_tb;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    ebtc_pkg::ebtc_cfg_t cfg = '{1'b0, 1'b0, 1'b1, 3'h0};
    ebtc_pkg::ebtc_wr_t wr = '{1'b0, 8'h00};
    logic clr = 1'b0;
    logic ien = 1'b0;
    logic slp = 1'b0;
    logic ext;
    logic [7:0] cnt;
    logic flag;
    logic irq;
    logic [7:0] a;
    logic wdt_tick = 1'b0;
    logic wdt_out;
    logic [7:0] wdt_seen = 8'h00;
    int num_errors = 0;
    int cmp_count = 0;
    int ticks = 0;
    // Clock and timeout
    initial forever #4 mclk = ~mclk;
    always @(posedge mclk)
    begin
        ticks++;
        if (ticks == 20000)
        begin
            num_errors++;
            conclude();
        end
    end
    ebtc_timer dut (.MCLK_IN(mclk), .NRST_IN(nrst), .CFG_IN(cfg), .COUNT_WR_IN(wr),
        .FLAG_CLR_IN(clr), .IRQ_ENABLE_IN(ien), .SLEEP_IN(slp), .EXT_COUNT_IN(ext),
        .WDT_TICK_IN(wdt_tick), .COUNT_OUT(cnt), .OVERFLOW_FLAG_OUT(flag), .IRQ_OUT(irq),
        .WDT_PRESCALED_OUT(wdt_out));
    ebtc_pulse_src u_src (.MCLK_IN(mclk), .PIN_OUT(ext));
    // Watchdog pulses counted at the falling edge, away from launch
    always @(negedge mclk)
        if (wdt_out === 1'b1)
            wdt_seen++;
    // Wait n clocks, land just after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // One cycle write of the count register
    task automatic wr_count(input logic [7:0] v);
        wr = '{1'b1, v};
        cyc(1);
        wr = '{1'b0, 8'h00};
    endtask
    // Increments seen over n clocks
    task automatic rate(input int n, input logic [7:0] want);
        a = cnt;
        cyc(n);
        `CHK(cnt - a, want)
    endtask
    task automatic conclude();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        cyc(8);
        nrst = 1'b1;
        `CHK({cnt, flag, irq}, 10'h000)
        cyc(20);
        rate(40, 8'h0A);
        wr_count(8'h40);
        cyc(47);
        `CHK(cnt == 8'h4A || cnt == 8'h49, 1'b1)
        for (int n = 0; n < 4; n++)
        begin
            cfg = '{1'b0, 1'b0, 1'b0, n[2:0]};
            wr_count(8'h00);
            cyc(64 << n);
            rate(32 << n, 8'h04);
        end
        cfg = '{1'b0, 1'b0, 1'b1, 3'h0};
        slp = 1'b1;
        cyc(8);
        rate(40, 8'h00);
        slp = 1'b0;
        `CHK(flag, 1'b0)
        wr_count(8'hFE);
        cyc(32);
        `CHK({flag, irq}, 2'b10)
        ien = 1'b1;
        cyc(2);
        `CHK(irq, 1'b1)
        cyc(100);
        `CHK(flag, 1'b1)
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(2);
        `CHK({flag, irq}, 2'b00)
        for (int e = 0; e < 2; e++)
        begin
            cfg = '{1'b1, e[0], 1'b1, 3'h0};
            cyc(10);
            a = cnt;
            u_src.send(5);
            cyc(10);
            `CHK(cnt - a, 8'h05)
        end
        for (int p = 0; p < 2; p++)
        begin
            cfg = '{1'b0, 1'b0, p[0], 3'h1};
            a = wdt_seen;
            wdt_tick = 1'b1;
            cyc(16);
            wdt_tick = 1'b0;
            cyc(2);
            `CHK(wdt_seen - a, p[0] ? 8'h04 : 8'h00)
        end
        conclude();
    end
endmodule
